// file: hdl/rf_mode_pkg.sv
// Constants, field layouts and carrier types for the front-end mode control.
// Assumes a 200 MHz clock and a classic Wishbone register bus.
// How it works
// - Power-up clears control, stays powered down.
// - Registers stay writable while powered down.
// - Enable bit 7 starts oscillator, regulators.
// - Interrupt when crystal oscillator becomes stable.
// - Separate receiver and transmitter enable bits.
// - Only wake-up bit set enters wake-up.
// - Wake-up measurement mismatch raises wake interrupt.
// - Single-driver bit runs only one driver.
// - Eight segments; normal level defaults all on.
// - Output select picks driven antenna output.
// - Modulation type bit picks AM or OOK.
// - OOK stops carrier; fast decay tristates.
// - AM turns on fewer segments than normal.
// - Calibrate command tunes AM level to target.
// - Receiver enable bit switches receiver on.
// - Channel count bit and auto/manual bit.
// - Receive-on gates RSSI, AGC, framing; timer sets.
// - Mask command clears, unmask sets receive-on.
// - Bit picks peak detector or mixer.
// - Low-frequency bypass skips demodulation.
package rf_mode_pkg;
  // Byte offsets of the registers.
  localparam logic [7:0] OFS_OP_CTRL = 8'h00;
  localparam logic [7:0] OFS_IO_CFG1 = 8'h04;
  localparam logic [7:0] OFS_IO_CFG2 = 8'h08;
  localparam logic [7:0] OFS_AUX_DEF = 8'h0C;
  localparam logic [7:0] OFS_NORM_LVL = 8'h10;
  localparam logic [7:0] OFS_AM_LVL = 8'h14;
  localparam logic [7:0] OFS_DEPTH = 8'h18;
  localparam logic [7:0] OFS_RX_CFG = 8'h1C;
  localparam logic [7:0] OFS_WAKE_PER = 8'h20;
  localparam logic [7:0] OFS_WAKE_REF = 8'h24;
  localparam logic [7:0] OFS_MASK_TIME = 8'h28;
  localparam logic [7:0] OFS_COMMAND = 8'h2C;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  // Bit positions.
  localparam int OP_EN = 7;
  localparam int OP_RX_EN = 6;
  localparam int OP_RX_BOTH = 5;
  localparam int OP_RX_MAN = 4;
  localparam int OP_TX_EN = 3;
  localparam int OP_WU = 2;
  localparam int OP_CHAN_PM = 1;
  localparam int IO1_SINGLE = 7;
  localparam int IO1_PORT_SEL = 6;
  localparam int IO2_SLOW_UP = 7;
  localparam int AUX_MOD_TYPE = 5;
  localparam int AUX_FAST_DECAY = 4;
  localparam int RXC_MIXER = 7;
  localparam int RXC_LF_BYPASS = 6;
  // Values after reset, and the control value that selects wake-up.
  localparam logic [7:0] OP_RESET = 8'h00;
  localparam logic [7:0] NORM_RESET = 8'hFF;
  localparam logic [7:0] WAKE_ONLY = 8'h04;
  // Direct command codes.
  localparam logic [7:0] CMD_CAL_DEPTH = 8'h01;
  localparam logic [7:0] CMD_MASK_RX = 8'h02;
  localparam logic [7:0] CMD_UNMASK_RX = 8'h03;
  // Timer tick: 1000 ns at a 5 ns clock.
  localparam int TICK_NS = 1000;
  localparam int CLK_NS = 5;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  typedef enum logic [1:0] {MODE_PD, MODE_READY, MODE_WAKE} mode_e;
  typedef enum logic [1:0] {CAL_IDLE, CAL_MEAS, CAL_WAIT} cal_e;
  // One antenna driver: segment enables and tristate.
  typedef struct packed {
    logic [7:0] seg;
    logic       hiz;
  } drv_s;
endpackage

// file: hdl/rf_frontend_mode_control.sv
// Mode sequencer, driver control and receive gating of the front end.
// Assumes a classic Wishbone master and same-clock framing logic;
// only the oscillator amplitude flag arrives asynchronously.
//
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module rf_frontend_mode_control (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output var  logic [31:0]        wb_dat_o,
  output var  logic               wb_ack_o,
  input  wire logic               osc_ok_i,
  input  wire logic               mod_i,
  input  wire logic               tx_end_i,
  input  wire logic               meas_done_i,
  input  wire logic [7:0]         meas_val_i,
  input  wire logic               adc_valid_i,
  input  wire logic [7:0]         adc_i,
  output var  logic               xtal_en_o,
  output var  logic               reg_en_o,
  output var  logic               rc_osc_en_o,
  output var  logic               osc_irq_o,
  output var  logic               wake_irq_o,
  output var  logic               wake_meas_o,
  output var  logic               cal_meas_o,
  output var  rf_mode_pkg::drv_s [1:0] drv_o,
  output var  logic               slow_ramp_o,
  output var  logic               rx_enable_o,
  output var  logic               am_chain_o,
  output var  logic               pm_chain_o,
  output var  logic               chan_auto_o,
  output var  logic               rx_on_o,
  output var  logic               mixer_sel_o,
  output var  logic               lowfreq_input_bypass_o
);
  // Software registers.
  logic [7:0] op_r;           // Operation control.
  logic [7:0] io1_r;          // Driver configuration.
  logic [7:0] io2_r;          // Slow ramp control.
  logic [7:0] aux_r;          // Modulation definition.
  logic [7:0] norm_r;         // Normal segment level.
  logic [7:0] am_r;           // Modulated segment level.
  logic [7:0] depth_r;        // Calibration target.
  logic [7:0] rxc_r;          // Receiver configuration.
  logic [7:0] wper_r;         // Wake period in ticks.
  logic [7:0] wref_r;         // Wake reference value.
  logic [7:0] mtime_r;        // Mask time in ticks.
  logic       ack_r;          // Bus acknowledge.
  logic [31:0] dat_r;         // Bus read data.
  // Internal state.
  rf_mode_pkg::mode_e mode_r; // Current operating mode.
  rf_mode_pkg::mode_e mode_nxt;
  rf_mode_pkg::cal_e  cal_r;  // Calibration sequencer.
  logic [2:0] osc_s_r;        // Oscillator flag synchroniser.
  logic       osc_ok_r;       // Filtered oscillator flag.
  logic       en_q_r;         // Enable bit one cycle late.
  logic       armed_r;        // Stable interrupt still owed.
  logic       osc_irq_r;
  logic       wake_irq_r;
  logic       wake_meas_r;
  logic       cal_meas_r;
  logic       wake_seen_r;    // Sticky wake mismatch status.
  logic [7:0] tick_r;         // Tick divider.
  logic       tick;
  logic [7:0] wcnt_r;         // Wake period counter.
  logic [7:0] mcnt_r;         // Mask timer counter.
  logic       mrun_r;         // Mask timer running.
  logic       rx_on_r;

  // Bus decode.
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire wr_go   = bus_req & ack_r & wb_we_i & wb_sel_i[0];
  wire [7:0] wd = wb_dat_i[7:0];
  wire wr_op   = wr_go & (wb_adr_i == rf_mode_pkg::OFS_OP_CTRL);
  wire wr_io1  = wr_go & (wb_adr_i == rf_mode_pkg::OFS_IO_CFG1);
  wire wr_io2  = wr_go & (wb_adr_i == rf_mode_pkg::OFS_IO_CFG2);
  wire wr_aux  = wr_go & (wb_adr_i == rf_mode_pkg::OFS_AUX_DEF);
  wire wr_norm = wr_go & (wb_adr_i == rf_mode_pkg::OFS_NORM_LVL);
  wire wr_am   = wr_go & (wb_adr_i == rf_mode_pkg::OFS_AM_LVL);
  wire wr_dep  = wr_go & (wb_adr_i == rf_mode_pkg::OFS_DEPTH);
  wire wr_rxc  = wr_go & (wb_adr_i == rf_mode_pkg::OFS_RX_CFG);
  wire wr_wper = wr_go & (wb_adr_i == rf_mode_pkg::OFS_WAKE_PER);
  wire wr_wref = wr_go & (wb_adr_i == rf_mode_pkg::OFS_WAKE_REF);
  wire wr_mt   = wr_go & (wb_adr_i == rf_mode_pkg::OFS_MASK_TIME);
  wire wr_cmd  = wr_go & (wb_adr_i == rf_mode_pkg::OFS_COMMAND);
  wire cmd_cal = wr_cmd & (wd == rf_mode_pkg::CMD_CAL_DEPTH);
  wire cmd_msk = wr_cmd & (wd == rf_mode_pkg::CMD_MASK_RX);
  wire cmd_unm = wr_cmd & (wd == rf_mode_pkg::CMD_UNMASK_RX);
  // Status word: mode, oscillator, wake, receive-on, calibration.
  wire [7:0] status = {2'h0, cal_r != rf_mode_pkg::CAL_IDLE,
                       rx_on_r, wake_seen_r, osc_ok_r, mode_r};
  // Read selection; unmapped addresses read as zero.
  wire [7:0] rd =
    (wb_adr_i == rf_mode_pkg::OFS_OP_CTRL)   ? op_r    :
    (wb_adr_i == rf_mode_pkg::OFS_IO_CFG1)   ? io1_r   :
    (wb_adr_i == rf_mode_pkg::OFS_IO_CFG2)   ? io2_r   :
    (wb_adr_i == rf_mode_pkg::OFS_AUX_DEF)   ? aux_r   :
    (wb_adr_i == rf_mode_pkg::OFS_NORM_LVL)  ? norm_r  :
    (wb_adr_i == rf_mode_pkg::OFS_AM_LVL)    ? am_r    :
    (wb_adr_i == rf_mode_pkg::OFS_DEPTH)     ? depth_r :
    (wb_adr_i == rf_mode_pkg::OFS_RX_CFG)    ? rxc_r   :
    (wb_adr_i == rf_mode_pkg::OFS_WAKE_PER)  ? wper_r  :
    (wb_adr_i == rf_mode_pkg::OFS_WAKE_REF)  ? wref_r  :
    (wb_adr_i == rf_mode_pkg::OFS_MASK_TIME) ? mtime_r :
    (wb_adr_i == rf_mode_pkg::OFS_STATUS)    ? status  : 8'h00;

  // Acknowledge one cycle after the request; data is loaded with it.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= bus_req & ~ack_r;
      if (bus_req & ~ack_r)
        dat_r <= {24'h00_0000, rd};
    end
  end

  // Configuration writes take effect in every mode.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      op_r    <= rf_mode_pkg::OP_RESET;
      io1_r   <= 8'h00;
      io2_r   <= 8'h00;
      aux_r   <= 8'h00;
      norm_r  <= rf_mode_pkg::NORM_RESET;
      depth_r <= 8'h00;
      rxc_r   <= 8'h00;
      wper_r  <= 8'h00;
      wref_r  <= 8'h00;
      mtime_r <= 8'h00;
    end
    else
    begin
      // Written regardless of the operating mode.
      if (wr_op)   op_r    <= wd;
      if (wr_io1)  io1_r   <= wd;
      if (wr_io2)  io2_r   <= wd;
      if (wr_aux)  aux_r   <= wd;
      if (wr_norm) norm_r  <= wd;
      if (wr_dep)  depth_r <= wd;
      if (wr_rxc)  rxc_r   <= wd;
      if (wr_wper) wper_r  <= wd;
      if (wr_wref) wref_r  <= wd;
      if (wr_mt)   mtime_r <= wd;
    end
  end

  // Mode follows the control bits; enable outranks wake-up.
  wire wake_only = (op_r == rf_mode_pkg::WAKE_ONLY);
  always_comb
  begin
    if (op_r[rf_mode_pkg::OP_EN])
      mode_nxt = rf_mode_pkg::MODE_READY;
    else if (wake_only)
      mode_nxt = rf_mode_pkg::MODE_WAKE;
    else
      mode_nxt = rf_mode_pkg::MODE_PD;
  end
  wire ready = (mode_r == rf_mode_pkg::MODE_READY);
  wire waking = (mode_r == rf_mode_pkg::MODE_WAKE);

  // Mode register and the power enables it drives.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_r      <= rf_mode_pkg::MODE_PD;
      xtal_en_o   <= 1'b0;
      reg_en_o    <= 1'b0;
      rc_osc_en_o <= 1'b0;
    end
    else
    begin
      mode_r      <= mode_nxt;
      xtal_en_o   <= op_r[rf_mode_pkg::OP_EN];
      reg_en_o    <= op_r[rf_mode_pkg::OP_EN];
      rc_osc_en_o <= wake_only;
    end
  end

  // Oscillator flag: three stages, accepted when the last two agree.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      osc_s_r  <= 3'h0;
      osc_ok_r <= 1'b0;
    end
    else
    begin
      osc_s_r <= {osc_s_r[1:0], osc_ok_i};
      if (osc_s_r[1] == osc_s_r[2])
        osc_ok_r <= osc_s_r[1];
    end
  end

  // Stable interrupt is armed by each rise of enable, fired once.
  wire en_rise = op_r[rf_mode_pkg::OP_EN] & ~en_q_r;
  wire osc_fire = armed_r & osc_ok_r & ready;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      en_q_r    <= 1'b0;
      armed_r   <= 1'b0;
      osc_irq_r <= 1'b0;
    end
    else
    begin
      en_q_r    <= op_r[rf_mode_pkg::OP_EN];
      osc_irq_r <= osc_fire;
      if (en_rise)
        armed_r <= 1'b1;
      else if (osc_fire | ~op_r[rf_mode_pkg::OP_EN])
        armed_r <= 1'b0;
    end
  end

  // Microsecond tick shared by the wake-up and mask timers.
  assign tick = (tick_r == 8'(rf_mode_pkg::TICK_CYC - 1));
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tick_r <= 8'h00;
    else
      tick_r <= tick ? 8'h00 : tick_r + 8'h01;
  end

  // Wake-up timer schedules measurements; mismatch wakes the host.
  wire wake_due = waking & tick & (wcnt_r >= wper_r);
  wire mismatch = waking & meas_done_i & (meas_val_i != wref_r);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wcnt_r      <= 8'h00;
      wake_meas_r <= 1'b0;
      wake_irq_r  <= 1'b0;
      wake_seen_r <= 1'b0;
    end
    else
    begin
      wake_meas_r <= wake_due;
      wake_irq_r  <= mismatch;
      if (!waking | wake_due)
        wcnt_r <= 8'h00;
      else if (tick)
        wcnt_r <= wcnt_r + 8'h01;
      // A new mismatch outranks leaving the wake-up mode.
      if (mismatch)
        wake_seen_r <= 1'b1;
      else if (mode_nxt != rf_mode_pkg::MODE_WAKE)
        wake_seen_r <= 1'b0;
    end
  end

  // Calibration: start from normal level, drop while too strong.
  wire too_high = adc_i > depth_r;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cal_r      <= rf_mode_pkg::CAL_IDLE;
      am_r       <= 8'h00;
      cal_meas_r <= 1'b0;
    end
    else
    begin
      cal_meas_r <= 1'b0;
      unique case (cal_r)
        rf_mode_pkg::CAL_IDLE:
        begin
          if (cmd_cal)
          begin
            am_r  <= norm_r;
            cal_r <= rf_mode_pkg::CAL_MEAS;
          end
          else if (wr_am)
            am_r <= wd;
        end
        rf_mode_pkg::CAL_MEAS:
        begin
          cal_meas_r <= 1'b1;
          cal_r      <= rf_mode_pkg::CAL_WAIT;
        end
        rf_mode_pkg::CAL_WAIT:
        begin
          if (adc_valid_i)
          begin
            if (too_high && am_r != 8'h00)
            begin
              am_r  <= am_r - 8'h01;
              cal_r <= rf_mode_pkg::CAL_MEAS;
            end
            else
              cal_r <= rf_mode_pkg::CAL_IDLE;
          end
        end
      endcase
    end
  end

  // Mask timer runs from the end of transmission; expiry opens rx.
  wire m_exp = mrun_r & tick & (mcnt_r >= mtime_r);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mcnt_r  <= 8'h00;
      mrun_r  <= 1'b0;
      rx_on_r <= 1'b0;
    end
    else
    begin
      if (tx_end_i)
      begin
        mcnt_r <= 8'h00;
        mrun_r <= 1'b1;
      end
      else if (m_exp)
        mrun_r <= 1'b0;
      else if (mrun_r & tick)
        mcnt_r <= mcnt_r + 8'h01;
      // Direct commands outrank the timer in the same cycle.
      if (cmd_msk)
        rx_on_r <= 1'b0;
      else if (cmd_unm)
        rx_on_r <= 1'b1;
      else if (m_exp)
        rx_on_r <= 1'b1;
    end
  end

  // Drive levels shared by both drivers.
  wire tx_live = ready & op_r[rf_mode_pkg::OP_TX_EN];
  wire ook = ~aux_r[rf_mode_pkg::AUX_MOD_TYPE];
  wire single = io1_r[rf_mode_pkg::IO1_SINGLE];
  wire psel = io1_r[rf_mode_pkg::IO1_PORT_SEL];
  // AM keeps only segments already on at normal level.
  wire [7:0] am_seg = am_r & norm_r;
  wire [7:0] mod_seg = ook ? 8'h00 : am_seg;
  wire [7:0] live_seg = mod_i ? mod_seg : norm_r;
  wire fast_off = mod_i & ook & aux_r[rf_mode_pkg::AUX_FAST_DECAY];

  // One register stage per antenna driver.
  genvar d;
  generate
    for (d = 0; d < 2; d++)
    begin : g_drv
      // Single mode drives only the selected output.
      wire used = ~single | (psel == (d == 1));
      wire on = tx_live & used;
      // Each driver owns its own state, so no variable has two writers.
      rf_mode_pkg::drv_s drv_q;
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          drv_q.seg <= 8'h00;
          drv_q.hiz <= 1'b1;
        end
        else
        begin
          drv_q.seg <= (on & ~fast_off) ? live_seg : 8'h00;
          drv_q.hiz <= ~on | fast_off;
        end
      end
    end
  endgenerate

  // Receiver controls and the slow ramp flag, registered for clean outputs.
  wire both = op_r[rf_mode_pkg::OP_RX_BOTH];
  wire pick_pm = op_r[rf_mode_pkg::OP_CHAN_PM];
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_enable_o <= 1'b0;
      am_chain_o  <= 1'b0;
      pm_chain_o  <= 1'b0;
      chan_auto_o <= 1'b0;
      mixer_sel_o <= 1'b0;
      lowfreq_input_bypass_o <= 1'b0;
      slow_ramp_o <= 1'b0;
    end
    else
    begin
      rx_enable_o <= ready & op_r[rf_mode_pkg::OP_RX_EN];
      am_chain_o  <= both | ~pick_pm;
      pm_chain_o  <= both | pick_pm;
      chan_auto_o <= both & ~op_r[rf_mode_pkg::OP_RX_MAN];
      mixer_sel_o <= rxc_r[rf_mode_pkg::RXC_MIXER];
      lowfreq_input_bypass_o <= rxc_r[rf_mode_pkg::RXC_LF_BYPASS];
      slow_ramp_o <= io2_r[rf_mode_pkg::IO2_SLOW_UP];
    end
  end

  assign wb_ack_o    = ack_r;
  assign wb_dat_o    = dat_r;
  assign osc_irq_o   = osc_irq_r;
  assign wake_irq_o  = wake_irq_r;
  assign wake_meas_o = wake_meas_r;
  assign cal_meas_o  = cal_meas_r;
  assign drv_o       = {g_drv[1].drv_q, g_drv[0].drv_q};
  assign rx_on_o     = rx_on_r;

  // Checks placed beside the logic they guard.
  pwr_down_a: assert property (@(posedge clk_i)
    rst_i |=> (!xtal_en_o && !reg_en_o && op_r == 8'h00 && mode_r == rf_mode_pkg::MODE_PD))
    else $error("not powered down after reset");
  ready_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    op_r[rf_mode_pkg::OP_EN] |=> (ready && xtal_en_o && reg_en_o))
    else $error("enable did not reach ready mode");
  osc_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (armed_r && osc_ok_r && ready) |=> osc_irq_r)
    else $error("stable interrupt missing");
  osc_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    osc_irq_r |-> (!armed_r && !$past(osc_irq_r)))
    else $error("stable interrupt repeated");
  wake_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (op_r == rf_mode_pkg::WAKE_ONLY) |=> (waking && rc_osc_en_o))
    else $error("wake-up mode not entered");
  wake_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (waking && meas_done_i && meas_val_i != wref_r) |=> (wake_irq_o && wake_seen_r))
    else $error("wake mismatch not reported");
  single_drv_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (single && !psel) |=> (drv_o[1].hiz && drv_o[1].seg == 8'h00))
    else $error("unselected driver active");
  ook_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_live && mod_i && ook) |=> (drv_o[0].seg == 8'h00 && drv_o[1].seg == 8'h00))
    else $error("carrier driven during keying");
  am_fewer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (mod_i && !ook) |=> ((drv_o[0].seg & ~$past(norm_r)) == 8'h00))
    else $error("modulated level exceeds normal");
  rx_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_msk |=> !rx_on_o)
    else $error("mask command ignored");
  mask_exp_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (m_exp && !cmd_msk) |=> rx_on_o)
    else $error("mask timer expiry did not open receive");
  rx_en_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ready && op_r[rf_mode_pkg::OP_RX_EN] && $stable(op_r)) |=> rx_enable_o)
    else $error("receiver not enabled");
endmodule
`default_nettype wire

// file: test/host_model.sv
// Host model: a classic Wishbone master that runs one cycle per call.
// Assumes the slave acks within the bench watchdog span.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output var  logic        cyc_o,
  output var  logic        stb_o,
  output var  logic        we_o,
  output var  logic [7:0]  adr_o,
  output var  logic [3:0]  sel_o,
  output var  logic [31:0] dat_o
);
  // The bus starts idle, so no request comes before reset is released.
  initial
  begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  // The request is held until the edge that samples ack high.
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= we;
    adr_o <= a;
    sel_o <= 4'hF;
    dat_o <= d;
    do
      @(posedge clk_i);
    while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: test/rf_frontend_mode_control_bench.sv
// Self-checking bench: a register model predicts reads and driver states.
// Assumes the host model is the only bus master.
`timescale 1ns/1ps
`default_nettype none
module rf_frontend_mode_control_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, osc_ok, mod, tx_end, meas_done, adc_valid;
  logic [7:0] adr, meas_val, adc;
  logic [3:0] sel;
  logic [31:0] dw, dr, rng = 32'hFAF5;
  logic [1:0] mix_lf;
  rf_mode_pkg::drv_s [1:0] drv;
  logic xtal, regen, rcosc, oirq, wirq, wmeas, rxen, rxon, mixer, lfb;
  logic calm, sramp, amc, pmc, autoc;
  int mdl [int];
  int mismatches = 0;
  int n_checks = 0;
  int i, k;
  // Clock at 200 MHz.
  always #2.5 clk_i = ~clk_i;
  host_model host (.clk_i(clk_i), .ack_i(ack), .dat_i(dr), .cyc_o(cyc), .stb_o(stb),
                   .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(dw));
  rf_frontend_mode_control dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
    .wb_dat_o(dr), .wb_ack_o(ack), .osc_ok_i(osc_ok), .mod_i(mod), .tx_end_i(tx_end),
    .meas_done_i(meas_done), .meas_val_i(meas_val), .adc_valid_i(adc_valid),
    .adc_i(adc), .xtal_en_o(xtal), .reg_en_o(regen), .rc_osc_en_o(rcosc),
    .osc_irq_o(oirq), .wake_irq_o(wirq), .wake_meas_o(wmeas), .cal_meas_o(calm),
    .drv_o(drv), .slow_ramp_o(sramp), .rx_enable_o(rxen), .am_chain_o(amc),
    .pm_chain_o(pmc), .chan_auto_o(autoc), .rx_on_o(rxon), .mixer_sel_o(mixer),
    .lowfreq_input_bypass_o(lfb));
  assign mix_lf = {mixer, lfb};
  // Compares one value and counts it.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Writes a register; the model keeps only mapped, stored registers.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
    if (a < 8'h2C)
      mdl[a] = d[7:0];
  endtask
  // Reads a register and compares it with the model.
  task automatic rd(input logic [7:0] a, input string name);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h0, q);
    check(name, q, mdl[a]);
  endtask
  // Lets registered outputs follow the last write.
  task automatic settle();
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  // Next value of the xorshift generator.
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Expected driver pair from the model and the modulation level.
  function automatic logic [17:0] drv_exp(input logic m);
    rf_mode_pkg::drv_s a, o;
    rf_mode_pkg::drv_s [1:0] r;
    o.seg = 8'h00;
    o.hiz = 1'b1;
    a.seg = m ? (mdl[12][5] ? 8'(mdl[20] & mdl[16]) : 8'h00) : 8'(mdl[16]);
    a.hiz = m && !mdl[12][5] && mdl[12][4];
    r = {a, a};
    if (mdl[4][7])
    begin
      r = {o, o};
      r[mdl[4][6]] = a;
    end
    return r;
  endfunction
  // Prints counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Watchdog cuts a hang short.
  initial
  begin
    repeat (30000) @(posedge clk_i);
    mismatches++;
    give_verdict();
  end
  // Main sequence.
  initial
  begin
    {osc_ok, mod, tx_end, meas_done, adc_valid, meas_val, adc} = '0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    mdl[0] = 0;
    mdl[16] = 8'hFF;
    mdl[60] = 0;
    @(negedge clk_i);
    check("xtal_en", xtal, 0);
    rd(8'h00, "op_ctrl");
    rd(8'h10, "norm_lvl");
    rng = xs(rng);
    wr(8'h10, {24'h0, rng[7:0]});
    wr(8'h14, {24'h0, rng[15:8]});
    rd(8'h10, "norm_pd");
    wr(8'h3C, 32'hAA);
    rd(8'h3C, "unmapped");
    wr(8'h20, 32'h1);
    wr(8'h24, 32'h55);
    wr(8'h00, 32'h04);
    settle();
    check("rc_osc", rcosc, 1);
    for (i = 0; i < 1000 && wmeas !== 1'b1; i++)
      @(posedge clk_i);
    meas_val <= 8'h56;
    meas_done <= 1'b1;
    @(posedge clk_i);
    meas_done <= 1'b0;
    @(negedge clk_i);
    check("wake_irq", wirq, 1);
    wr(8'h00, 32'h80);
    settle();
    check("ready", {xtal, regen, rcosc}, 3'b110);
    @(posedge clk_i);
    osc_ok <= 1'b1;
    for (i = 0; i < 20 && oirq !== 1'b1; i++)
      @(negedge clk_i);
    check("osc_irq", oirq, 1);
    k = 0;
    repeat (20)
    begin
      @(negedge clk_i);
      k += (oirq === 1'b1);
    end
    check("osc_irq_again", k, 0);
    // Slow ramp is raised while the transmitter is off and cleared before
    // any command; the 2 ms discharge hold is shortened to keep the run short.
    wr(8'h08, 32'h80);
    settle();
    check("slow_ramp", sramp, 1);
    wr(8'h00, 32'hE8);
    wr(8'h08, 32'h0);
    settle();
    check("rx_en", rxen, 1);
    check("chains_auto", {amc, pmc, autoc}, 3'b111);
    check("slow_done", sramp, 0);
    for (i = 0; i < 9; i++)
    begin
      wr(8'h0C, (i % 3) * 16);
      wr(8'h04, (i > 2 ? 128 : 0) + (i / 3 == 1 ? 64 : 0));
      mod <= i[0];
      settle();
      check("drv", drv, drv_exp(i[0]));
    end
    // Calibration: two strong readings step the level down, a weak one ends it.
    wr(8'h18, 32'h40);
    wr(8'h2C, 32'h1);
    for (k = 0; k < 3; k++)
    begin
      for (i = 0; i < 20 && calm !== 1'b1; i++)
        @(posedge clk_i);
      adc <= (k < 2) ? 8'h50 : 8'h30;
      adc_valid <= 1'b1;
      @(posedge clk_i);
      adc_valid <= 1'b0;
    end
    mdl[20] = (mdl[16] > 1) ? mdl[16] - 2 : 0;
    rd(8'h14, "am_cal");
    wr(8'h1C, 32'hC0);
    settle();
    check("mix_lf", mix_lf, 2'b11);
    wr(8'h28, 32'h1);
    wr(8'h2C, 32'h3);
    settle();
    check("rx_on_unmask", rxon, 1);
    wr(8'h2C, 32'h2);
    settle();
    check("rx_on_mask", rxon, 0);
    @(posedge clk_i);
    tx_end <= 1'b1;
    @(posedge clk_i);
    tx_end <= 1'b0;
    for (i = 0; i < 1000 && rxon !== 1'b1; i++)
      @(negedge clk_i);
    check("rx_on_timer", rxon, 1);
    wr(8'h00, 32'h8A);
    settle();
    check("rx_off_tx_on", {rxen, drv[0].hiz}, 2'b00);
    check("chains_pm", {amc, pmc, autoc}, 3'b010);
    give_verdict();
  end
endmodule
`default_nettype wire
